// File: common/mbz_pkg.sv
package mbz_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          MSG_BYTES       = 4;

  localparam logic [7:0]  OFS_CONTROL     = 8'h90;
  localparam logic [7:0]  OFS_STATUS      = 8'h91;
  localparam logic [7:0]  OFS_BYTE0       = 8'h92;
  localparam logic [7:0]  OFS_BYTE3       = 8'h95;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'hA0;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'hA1;

  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  CONTROL_MASK    = 8'h3F;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  localparam int          CTL_EN_BIT      = 0;
  localparam int          CTL_DIR_BIT     = 1;
  localparam int          CTL_EIEN_BIT    = 2;
  localparam int          CTL_FIEN_BIT    = 3;
  localparam int          CTL_LEN_LSB     = 4;
  localparam int          ST_FULL_BIT     = 0;
  localparam int          ST_EMPTY_BIT    = 1;
  localparam int          ST_FIRQ_BIT     = 4;
  localparam int          ST_EIRQ_BIT     = 5;

  localparam logic        DIR_RECEIVE     = 1'b0;
  localparam logic        DIR_TRANSMIT    = 1'b1;

  // Sticky event bits: full event at bit 0, empty event at bit 1
  localparam int          EV_W            = 2;

  typedef struct packed {
    logic [1:0] message_length_field;
    logic       full_interrupt_enable;
    logic       empty_interrupt_enable;
    logic       mailbox_direction;
    logic       mailbox_enable;
  } mbz_ctl_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mbz_req_t;

endpackage

// File: rtl/mbz_sticky.sv
`timescale 1ns/100ps
module mbz_sticky
  import mbz_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag
);

  logic flag_reg;

  // Set wins over a same-cycle clear so no event is lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (set_pulse) begin
      flag_reg <= 1'b1;
    end else if (clear_pulse) begin
      flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;

endmodule // mbz_sticky

// File: rtl/mbz_mailbox.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
// Contract
// - Bits 5:4 select 1 to 4 bytes
// - Bit 3 enables interrupt on full
// - Bit 2 enables interrupt on empty
// - Bit 1: zero receive, one transmit
// - Mailbox runs only while bit 0 set
// - Present only in a subordinate node
// - Status bits 1 empty, 0 full
// - Status bits 5 empty irq, 4 full irq
// - Four byte registers, byte 0 lowest
module mbz_mailbox
  import mbz_pkg::*;
#(
  parameter bit SUBORDINATE_NODE = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [1:0]        far_byte_sel,
  input  wire logic [DATA_W-1:0] far_wdata,
  input  wire logic              far_wr,
  input  wire logic              far_rd,
  output logic      [DATA_W-1:0] far_rdata,
  output logic                   mailbox_full_flag,
  output logic                   mailbox_empty_flag,
  output logic                   irq
);

  mbz_req_t          req;
  mbz_ctl_t          ctl_reg;
  logic [7:0]        data_reg [MSG_BYTES];
  logic              full_reg;
  logic [EV_W-1:0]   mask_reg;
  logic [EV_W-1:0]   sticky;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] far_rdata_reg;
  logic              active;
  logic              tx_mode;
  logic [1:0]        last_idx;
  logic              local_wr_data;
  logic [1:0]        local_idx;
  logic              full_set;
  logic              empty_set;
  logic              full_irq_active;
  logic              empty_irq_active;
  logic [7:0]        status_val;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // A main-node build ties off all but the IRQ mask register
  assign active   = SUBORDINATE_NODE && ctl_reg.mailbox_enable;
  assign tx_mode  = ctl_reg.mailbox_direction == DIR_TRANSMIT;
  assign last_idx = ctl_reg.message_length_field;

  assign local_wr_data = req.wr && req.addr >= OFS_BYTE0 && req.addr <= OFS_BYTE3;
  assign local_idx     = 2'(req.addr - OFS_BYTE0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_reg <= mbz_ctl_t'(CONTROL_RESET[5:0]);
    end else if (req.wr && req.addr == OFS_CONTROL && SUBORDINATE_NODE) begin
      ctl_reg <= mbz_ctl_t'(req.wdata[5:0]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_reg <= MASK_RESET[EV_W-1:0];
    end else if (req.wr && req.addr == OFS_IRQ_MASK) begin
      mask_reg <= req.wdata[EV_W-1:0];
    end
  end

  // Local host writes bytes in any mode, far node only in receive mode while enabled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MSG_BYTES; i++) begin
        data_reg[i] <= 8'h00;
      end
    end else if (local_wr_data && SUBORDINATE_NODE) begin
      data_reg[local_idx] <= req.wdata;
    end else if (far_wr && active && !tx_mode) begin
      data_reg[far_byte_sel] <= far_wdata;
    end
  end

  // Writer storing the last byte fills it; reader taking it drains it
  always_comb begin
    full_set  = 1'b0;
    empty_set = 1'b0;
    if (active) begin
      if (tx_mode) begin
        full_set  = local_wr_data && local_idx == last_idx;
        empty_set = full_reg && far_rd && far_byte_sel == last_idx;
      end else begin
        full_set  = far_wr && far_byte_sel == last_idx;
        empty_set = full_reg && req.rd && req.addr == OFS_BYTE0 + 8'(last_idx);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      full_reg <= 1'b0;
    end else if (!active) begin
      full_reg <= 1'b0;
    end else if (full_set) begin
      full_reg <= 1'b1;
    end else if (empty_set) begin
      full_reg <= 1'b0;
    end
  end

  assign mailbox_full_flag  = full_reg;
  assign mailbox_empty_flag = !full_reg;

  for (genvar g = 0; g < EV_W; g++) begin : g_sticky
    mbz_sticky u_sticky (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .set_pulse   (g == 0 ? (full_set && ctl_reg.full_interrupt_enable)
                           : (empty_set && ctl_reg.empty_interrupt_enable)),
      .clear_pulse (req.wr && req.addr == OFS_IRQ_STATUS && req.wdata[g]),
      .flag        (sticky[g])
    );
  end

  assign full_irq_active  = sticky[0];
  assign empty_irq_active = sticky[1];
  assign irq              = |(sticky & mask_reg);

  always_comb begin
    status_val                = 8'h00;
    status_val[ST_FULL_BIT]   = mailbox_full_flag;
    status_val[ST_EMPTY_BIT]  = mailbox_empty_flag;
    status_val[ST_FIRQ_BIT]   = full_irq_active;
    status_val[ST_EIRQ_BIT]   = empty_irq_active;
  end

  // Unmapped addresses read zero; data stands one cycle only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= UNMAPPED_READ;
    end else if (req.rd && SUBORDINATE_NODE) begin
      if (req.addr == OFS_CONTROL) begin
        rdata_reg <= {2'b00, ctl_reg};
      end else if (req.addr == OFS_STATUS) begin
        rdata_reg <= status_val;
      end else if (req.addr >= OFS_BYTE0 && req.addr <= OFS_BYTE3) begin
        rdata_reg <= data_reg[local_idx];
      end else if (req.addr == OFS_IRQ_STATUS) begin
        rdata_reg <= {6'h00, sticky};
      end else if (req.addr == OFS_IRQ_MASK) begin
        rdata_reg <= {6'h00, mask_reg};
      end else begin
        rdata_reg <= UNMAPPED_READ;
      end
    end else begin
      rdata_reg <= UNMAPPED_READ;
    end
  end

  assign reg_rdata = rdata_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      far_rdata_reg <= 8'h00;
    end else if (far_rd && active) begin
      far_rdata_reg <= data_reg[far_byte_sel];
    end
  end

  assign far_rdata = far_rdata_reg;

  a_len_full: assert property (@(posedge clk_sys) disable iff (rst)
    active && tx_mode && local_wr_data && local_idx == last_idx |=> full_reg)
    else $error("full not set after last byte");
  a_full_irq_gate: assert property (@(posedge clk_sys) disable iff (rst)
    full_set && !ctl_reg.full_interrupt_enable && !sticky[0] |=> !sticky[0])
    else $error("full irq without enable");
  a_full_irq_set: assert property (@(posedge clk_sys) disable iff (rst)
    full_set && ctl_reg.full_interrupt_enable |=> sticky[0])
    else $error("full irq missing");
  a_empty_irq_set: assert property (@(posedge clk_sys) disable iff (rst)
    empty_set && ctl_reg.empty_interrupt_enable |=> sticky[1])
    else $error("empty irq missing");
  a_rx_local_no_fill: assert property (@(posedge clk_sys) disable iff (rst)
    active && !tx_mode && !far_wr && !full_reg |=> !full_reg)
    else $error("receive filled without far write");
  a_disabled_empty: assert property (@(posedge clk_sys) disable iff (rst)
    !ctl_reg.mailbox_enable |=> mailbox_empty_flag)
    else $error("disabled mailbox not empty");
  a_status_read: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == OFS_STATUS ##1 1'b1 |-> reg_rdata[ST_FULL_BIT] == $past(full_reg))
    else $error("status full bit wrong");
  a_drain_empty: assert property (@(posedge clk_sys) disable iff (rst)
    empty_set && !full_set |=> !full_reg && mailbox_empty_flag)
    else $error("not empty after drain");
  a_byte_store: assert property (@(posedge clk_sys) disable iff (rst)
    SUBORDINATE_NODE && local_wr_data |=> data_reg[$past(local_idx)] == $past(req.wdata))
    else $error("byte not stored");

  c_tx_fill: cover property (@(posedge clk_sys) disable iff (rst) active && tx_mode && full_set);
  c_tx_drain: cover property (@(posedge clk_sys) disable iff (rst) tx_mode && empty_set);
  c_rx_fill: cover property (@(posedge clk_sys) disable iff (rst) !tx_mode && full_set);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);

endmodule // mbz_mailbox

// File: test/mbz_far_model.sv
`timescale 1ns/100ps
module mbz_far_model
  import mbz_pkg::*;
(
  input  wire logic              clk_sys,
  output logic      [1:0]        far_byte_sel,
  output logic      [DATA_W-1:0] far_wdata,
  output logic                   far_wr,
  output logic                   far_rd,
  input  wire logic [DATA_W-1:0] far_rdata
);
  initial begin
    far_byte_sel = 2'h0;
    far_wdata    = 8'h00;
    far_wr       = 1'b0;
    far_rd       = 1'b0;
  end
  task automatic put(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    far_wr       <= 1'b1;
    far_byte_sel <= s;
    far_wdata    <= d;
    @(posedge clk_sys);
    far_wr    <= 1'b0;
    far_wdata <= ~d; // Released data must not echo the last byte
  endtask
  // Reading the last byte is what drains a transmit mailbox
  task automatic get(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk_sys);
    far_rd       <= 1'b1;
    far_byte_sel <= s;
    @(posedge clk_sys);
    far_rd <= 1'b0;
    #1 d = far_rdata;
  endtask
endmodule // mbz_far_model

// File: test/tb_mbz_mailbox.sv
`timescale 1ns/100ps
module tb_mbz_mailbox;
  import mbz_pkg::*;
  logic              clk_sys, rst, reg_wr, reg_rd, far_wr, far_rd, full, empty, irq, m_full;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, far_wdata, far_rdata, m_rdata, d, m_d;
  logic [1:0]        far_byte_sel;
  int                error_cnt, n_compared, cyc;
  mbz_mailbox mbz_mailbox_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .far_byte_sel(far_byte_sel), .far_wdata(far_wdata), .far_wr(far_wr), .far_rd(far_rd),
    .far_rdata(far_rdata), .mailbox_full_flag(full), .mailbox_empty_flag(empty), .irq(irq));
  // Main-node build sees the same traffic and must stay inert
  mbz_mailbox #(.SUBORDINATE_NODE(1'b0)) main_mbz_mailbox_inst (.clk_sys(clk_sys),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(m_rdata), .far_byte_sel(far_byte_sel),
    .far_wdata(far_wdata), .far_wr(far_wr), .far_rd(far_rd), .far_rdata(),
    .mailbox_full_flag(m_full), .mailbox_empty_flag(), .irq());
  mbz_far_model mbz_far_model_inst (.clk_sys(clk_sys), .far_byte_sel(far_byte_sel),
    .far_wdata(far_wdata), .far_wr(far_wr), .far_rd(far_rd), .far_rdata(far_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    m_d = m_rdata;
    chk(e, d);
  endtask
  task automatic t_reset();
    rd(OFS_CONTROL, 8'h00);
    rd(OFS_IRQ_MASK, 8'h00);
    rd(8'h7F, 8'h00);
    rd(OFS_STATUS, 8'h02);
    chk(8'h01, {6'h0, full, empty});
  endtask
  task automatic t_tx();
    wr(OFS_CONTROL, 8'h1B);
    rd(OFS_CONTROL, 8'h1B);
    chk(8'h00, m_d);
    wr(OFS_BYTE0, 8'hA5);
    rd(OFS_STATUS, 8'h02);
    wr(8'h93, 8'h5C);
    rd(OFS_STATUS, 8'h11);
    chk(8'h00, {7'h0, irq});
    chk(8'h00, {7'h0, m_full});
    rd(OFS_IRQ_MASK, 8'h00);
    wr(OFS_IRQ_MASK, 8'h03);
    rd(OFS_IRQ_MASK, 8'h03);
    chk(8'h01, {7'h0, irq});
    mbz_far_model_inst.get(2'h0, m_d);
    chk(8'hA5, m_d);
    rd(OFS_STATUS, 8'h11);
    mbz_far_model_inst.get(2'h1, m_d);
    chk(8'h5C, m_d);
    rd(OFS_STATUS, 8'h12);
    wr(OFS_IRQ_STATUS, 8'h01);
    rd(OFS_STATUS, 8'h02);
    chk(8'h00, {7'h0, irq});
  endtask
  task automatic t_rx();
    wr(OFS_CONTROL, 8'h35);
    wr(OFS_IRQ_STATUS, 8'h03);
    for (int i = 0; i < 4; i++) mbz_far_model_inst.put(i[1:0], 8'h10 + i[7:0]);
    rd(OFS_STATUS, 8'h01);
    chk(8'h02, {6'h0, full, empty});
    rd(OFS_BYTE0, 8'h10);
    rd(OFS_STATUS, 8'h01);
    rd(OFS_BYTE3, 8'h13);
    rd(OFS_STATUS, 8'h22);
    chk(8'h01, {7'h0, irq});
    wr(OFS_IRQ_STATUS, 8'h02);
  endtask
  task automatic t_off();
    wr(OFS_CONTROL, 8'h02);
    wr(OFS_BYTE0, 8'h77);
    rd(OFS_STATUS, 8'h02);
    mbz_far_model_inst.put(2'h0, 8'hEE);
    rd(OFS_BYTE0, 8'h77);
    wr(OFS_CONTROL, 8'h03);
    mbz_far_model_inst.put(2'h0, 8'hEE);
    rd(OFS_BYTE0, 8'h77);
    rd(OFS_STATUS, 8'h02);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_off();
    stop_test();
  end
endmodule // tb_mbz_mailbox
